// File: pkg/tmps_pkg.sv
// package for the trunk and mirror port selection block
// holds register offsets, field positions, reset values and the carrier structs;
// assumes a 10 port switch with the cpu at port 8 and the uplink at port 9
package tmps_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // port numbering
    localparam int          NUM_PORTS   = 10;
    localparam int          NUM_GROUPS  = 8;
    localparam int          GROUP_SLOTS = 8;
    localparam logic [3:0]  FAST_LAST   = 4'h7;   // fast ports are 0 through 7
    localparam logic [3:0]  CPU_PORT    = 4'h8;
    localparam logic [3:0]  UPLINK_PORT = 4'h9;

    ////////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [7:0]  OFS_CTRL      = 8'h00;
    localparam logic [7:0]  OFS_MON       = 8'h04;
    localparam logic [7:0]  OFS_FSA_LO    = 8'h08;
    localparam logic [7:0]  OFS_FSA_HI    = 8'h0c;
    localparam logic [7:0]  OFS_FDA_LO    = 8'h10;
    localparam logic [7:0]  OFS_FDA_HI    = 8'h14;
    localparam logic [7:0]  OFS_STAT      = 8'h18;
    localparam logic [2:0]  OFS_MEMB_PAGE = 3'h1;  // 0x20..0x3c, one word per group
    localparam logic [2:0]  OFS_SLOT_PAGE = 3'h2;  // 0x40..0x5c, one word per group

    ////////////////////////////////////////////////////////////////////////////
    // control register fields
    localparam int          CTRL_HASH_LSB = 0;     // two bits of hash mode
    localparam int          CTRL_RING     = 2;
    localparam int          CTRL_FLOW_EN  = 3;
    localparam int          CTRL_FLOW_REV = 4;
    localparam int          CTRL_ADDR_DST = 5;     // 0: match source, 1: match destination
    localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;

    // monitor register fields
    localparam int          MON0_PORT_LSB = 0;
    localparam int          MON0_EN       = 4;
    localparam int          MON0_EGR      = 5;
    localparam int          MON1_PORT_LSB = 8;
    localparam int          MON1_EN       = 12;
    localparam int          MON1_EGR      = 13;
    localparam int          MON_OBS_LSB   = 16;    // observed port for port mirroring
    localparam logic [31:0] MON_RESET     = 32'h0000_0000;
    localparam logic [31:0] MAC_RESET     = 32'h0000_0000;
    localparam logic [9:0]  MEMB_RESET    = 10'h000;
    localparam logic [31:0] SLOT_RESET    = 32'h0000_0000;

    // hash modes
    localparam logic [1:0]  HASH_SA_DA    = 2'h0;
    localparam logic [1:0]  HASH_SA       = 2'h1;
    localparam logic [1:0]  HASH_DA       = 2'h2;
    localparam logic [1:0]  HASH_SRC_PORT = 2'h3;

    // axi responses
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    ////////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic        valid;
        logic        multicast;
        logic [3:0]  src_port;
        logic [47:0] src_mac;
        logic [47:0] dst_mac;
        logic [3:0]  dst_port;         // port found by the destination lookup
        logic        dst_trunk;        // entry status marks an aggregation member
        logic [2:0]  dst_group;
        logic        src_mirror_flag;  // mirror flag of the source address entry
        logic        dst_mirror_flag;  // mirror flag of the destination address entry
        logic [9:0]  vlan_members;
    } tmps_req_t;

    typedef struct packed {
        logic        valid;
        logic        discard;
        logic [9:0]  fwd_mask;
        logic [9:0]  mirror_mask;
    } tmps_res_t;

endpackage

// File: hw/tmps_select.sv
// trunk and mirror destination port selection with its axi4-lite register slave
// assumes one lookup result per cycle at most from the search engine, already
// synchronous to clock; the result appears one cycle after the request
//
// The AXI4-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
module tmps_select
    import tmps_pkg::*;
(
    // clock and reset
    input  wire logic              clock,
    input  wire logic              rst,
    // lookup request and selection result
    input  wire tmps_pkg::tmps_req_t req,
    output tmps_pkg::tmps_res_t    res,
    // axi4-lite write channels
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // axi4-lite read channels
    input  wire logic [7:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);
    import tmps_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [9:0] port_bit(input logic [3:0] p);
        port_bit = (p < 4'(NUM_PORTS)) ? (10'h001 << p) : 10'h000;
    endfunction

    // folding all 48 bits keeps every address bit in the key
    function automatic logic [2:0] fold48(input logic [47:0] v);
        logic [2:0] k;
        k = 3'h0;
        for (int i = 0; i < 16; i++) begin
            k = k ^ v[3*i +: 3];
        end
        fold48 = k;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] st);
        logic [31:0] m;
        m = old;
        for (int b = 0; b < 4; b++) begin
            if (st[b]) begin
                m[8*b +: 8] = nw[8*b +: 8];
            end
        end
        merge = m;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // register state
    logic [31:0] ctrl_reg;
    logic [31:0] mon_reg;
    logic [31:0] fsa_lo_reg;
    logic [31:0] fsa_hi_reg;
    logic [31:0] fda_lo_reg;
    logic [31:0] fda_hi_reg;
    logic [9:0]  memb_reg [NUM_GROUPS];
    logic [31:0] slot_reg [NUM_GROUPS];
    logic [15:0] frame_cnt_reg;
    logic [15:0] discard_cnt_reg;

    // axi slave state
    logic        aw_have_reg;
    logic [7:0]  aw_addr_reg;
    logic        w_have_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;

    ////////////////////////////////////////////////////////////////////////////
    // write channel handshakes; address and data are taken in either order
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take  = s_axi_wvalid && s_axi_wready;
    wire wr_go   = aw_have_reg && w_have_reg;
    assign s_axi_awready = !aw_have_reg && !bvalid_reg;
    assign s_axi_wready  = !w_have_reg && !bvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;

    // write decode
    wire       wr_memb = (aw_addr_reg[7:5] == OFS_MEMB_PAGE);
    wire       wr_slot = (aw_addr_reg[7:5] == OFS_SLOT_PAGE);
    wire [2:0] wr_grp  = aw_addr_reg[4:2];
    wire       wr_hit  = wr_memb || wr_slot || aw_addr_reg == OFS_CTRL
                      || aw_addr_reg == OFS_MON || aw_addr_reg == OFS_FSA_LO
                      || aw_addr_reg == OFS_FSA_HI || aw_addr_reg == OFS_FDA_LO
                      || aw_addr_reg == OFS_FDA_HI || aw_addr_reg == OFS_STAT;

    // holding stages for the two write channels
    always_ff @(posedge clock) begin
        if (rst) begin
            aw_have_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_have_reg  <= 1'b0;
            w_data_reg  <= 32'h0000_0000;
            w_strb_reg  <= 4'h0;
        end else begin
            if (aw_take) begin
                aw_have_reg <= 1'b1;
                aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
            end else if (wr_go) begin
                aw_have_reg <= 1'b0;
            end
            if (w_take) begin
                w_have_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end else if (wr_go) begin
                w_have_reg <= 1'b0;
            end
        end
    end

    // write response; status is read only and answers okay with no effect
    always_ff @(posedge clock) begin
        if (rst) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // scalar configuration registers
    always_ff @(posedge clock) begin
        if (rst) begin
            ctrl_reg   <= CTRL_RESET;
            mon_reg    <= MON_RESET;
            fsa_lo_reg <= MAC_RESET;
            fsa_hi_reg <= MAC_RESET;
            fda_lo_reg <= MAC_RESET;
            fda_hi_reg <= MAC_RESET;
        end else if (wr_go) begin
            if (aw_addr_reg == OFS_CTRL)   ctrl_reg   <= merge(ctrl_reg, w_data_reg, w_strb_reg);
            if (aw_addr_reg == OFS_MON)    mon_reg    <= merge(mon_reg, w_data_reg, w_strb_reg);
            if (aw_addr_reg == OFS_FSA_LO) fsa_lo_reg <= merge(fsa_lo_reg, w_data_reg, w_strb_reg);
            if (aw_addr_reg == OFS_FSA_HI) fsa_hi_reg <= merge(fsa_hi_reg, w_data_reg, w_strb_reg);
            if (aw_addr_reg == OFS_FDA_LO) fda_lo_reg <= merge(fda_lo_reg, w_data_reg, w_strb_reg);
            if (aw_addr_reg == OFS_FDA_HI) fda_hi_reg <= merge(fda_hi_reg, w_data_reg, w_strb_reg);
        end
    end

    // per group membership and selector slots
    for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_grp_regs
        always_ff @(posedge clock) begin
            if (rst) begin
                memb_reg[g] <= MEMB_RESET;
                slot_reg[g] <= SLOT_RESET;
            end else if (wr_go && wr_grp == 3'(g)) begin
                if (wr_memb) begin
                    memb_reg[g] <= 10'(merge({22'h0, memb_reg[g]}, w_data_reg, w_strb_reg));
                end
                if (wr_slot) begin
                    // a new slot map takes effect on the very next frame
                    slot_reg[g] <= merge(slot_reg[g], w_data_reg, w_strb_reg);
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read channel: one cycle from the address handshake to rvalid
    wire       ar_take = s_axi_arvalid && s_axi_arready;
    wire [7:0] ar_addr = {s_axi_araddr[7:2], 2'b00};
    wire [2:0] rd_grp  = ar_addr[4:2];
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    // read mux; unmapped words read zero with slverr
    logic [31:0] rd_val;
    logic        rd_ok;
    always_comb begin
        rd_ok  = 1'b1;
        rd_val = 32'h0000_0000;
        if (ar_addr[7:5] == OFS_MEMB_PAGE) begin
            rd_val = {22'h0, memb_reg[rd_grp]};
        end else if (ar_addr[7:5] == OFS_SLOT_PAGE) begin
            rd_val = slot_reg[rd_grp];
        end else begin
            case (ar_addr)
                OFS_CTRL:   rd_val = ctrl_reg;
                OFS_MON:    rd_val = mon_reg;
                OFS_FSA_LO: rd_val = fsa_lo_reg;
                OFS_FSA_HI: rd_val = {16'h0, fsa_hi_reg[15:0]};
                OFS_FDA_LO: rd_val = fda_lo_reg;
                OFS_FDA_HI: rd_val = {16'h0, fda_hi_reg[15:0]};
                OFS_STAT:   rd_val = {discard_cnt_reg, frame_cnt_reg};
                default:    rd_ok  = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= RESP_OKAY;
        end else if (ar_take) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_val;
            rresp_reg  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // hash key; source port mode outside ring mode falls back to sa+da
    wire [1:0]  hash_mode = ctrl_reg[CTRL_HASH_LSB +: 2];
    wire        ring_mode = ctrl_reg[CTRL_RING];
    wire [2:0]  key_sada  = fold48(req.src_mac ^ req.dst_mac);
    wire [2:0]  hash_key  = (hash_mode == HASH_SA) ? fold48(req.src_mac)
                          : (hash_mode == HASH_DA) ? fold48(req.dst_mac)
                          : (hash_mode == HASH_SRC_PORT && ring_mode) ? req.src_port[2:0]
                          : key_sada;

    // the cpu port (8) and uplink (9) are ordinary members of the port masks
    wire [9:0] src_mask = port_bit(req.src_port);

    // per group: membership of the ingress port, chosen member and pruned members
    logic [9:0] sel_mask   [NUM_GROUPS];
    logic [9:0] prune_mask [NUM_GROUPS];
    logic [9:0] excl_mask  [NUM_GROUPS];
    logic       src_in     [NUM_GROUPS];
    for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_grp_sel
        assign src_in[g]     = |(memb_reg[g] & src_mask);
        assign sel_mask[g]   = port_bit(slot_reg[g][4*hash_key +: 4]) & memb_reg[g];
        assign prune_mask[g] = memb_reg[g] & ~sel_mask[g];
        assign excl_mask[g]  = src_in[g] ? memb_reg[g] : 10'h000;
    end

    logic [9:0] excl_all;
    logic [9:0] prune_all;
    always_comb begin
        excl_all  = 10'h000;
        prune_all = 10'h000;
        for (int g = 0; g < NUM_GROUPS; g++) begin
            excl_all  = excl_all | excl_mask[g];
            prune_all = prune_all | prune_mask[g];
        end
    end

    // multicast: vlan set minus ingress port and group, one member per group
    wire [9:0] mc_dest = req.vlan_members & ~src_mask & ~excl_all & ~prune_all;

    // unicast: trunk destinations use the hash slot, others the found port
    wire       uc_drop = req.dst_trunk && src_in[req.dst_group];
    wire [9:0] uc_dest = req.dst_trunk ? sel_mask[req.dst_group]
                                       : port_bit(req.dst_port);
    wire       discard = !req.multicast && uc_drop;
    wire [9:0] dest    = discard ? 10'h000 : (req.multicast ? mc_dest : uc_dest);

    ////////////////////////////////////////////////////////////////////////////
    // monitor ports; the observed port may equal a monitor for loopback
    wire [3:0] mon0_port = mon_reg[MON0_PORT_LSB +: 4];
    wire [3:0] mon1_port = mon_reg[MON1_PORT_LSB +: 4];
    wire [3:0] obs_port  = mon_reg[MON_OBS_LSB +: 4];
    wire [9:0] mon0_mask = mon_reg[MON0_EN] ? port_bit(mon0_port) : 10'h000;
    wire [9:0] mon1_mask = mon_reg[MON1_EN] ? port_bit(mon1_port) : 10'h000;
    wire [9:0] mon_all   = mon0_mask | mon1_mask;
    wire [9:0] fwd       = dest & ~mon_all;

    // port mirroring is limited to the fast ports as the observed port
    wire obs_fast  = (obs_port <= FAST_LAST);
    wire obs_in    = obs_fast && req.src_port == obs_port;
    wire obs_out   = obs_fast && |(fwd & port_bit(obs_port));
    wire port_hit0 = mon_reg[MON0_EN] && (mon_reg[MON0_EGR] ? obs_out : obs_in);
    wire port_hit1 = mon_reg[MON1_EN] && (mon_reg[MON1_EGR] ? obs_out : obs_in);

    // address and flow mirroring copy to monitor 0
    wire addr_hit = ctrl_reg[CTRL_ADDR_DST] ? req.dst_mirror_flag
                                            : req.src_mirror_flag;
    wire [47:0] flow_sa = {fsa_hi_reg[15:0], fsa_lo_reg};
    wire [47:0] flow_da = {fda_hi_reg[15:0], fda_lo_reg};
    wire fwd_pair = req.src_mac == flow_sa && req.dst_mac == flow_da;
    wire rev_pair = req.src_mac == flow_da && req.dst_mac == flow_sa;
    wire flow_hit = ctrl_reg[CTRL_FLOW_EN]
                 && (fwd_pair || (ctrl_reg[CTRL_FLOW_REV] && rev_pair));
    wire hit0     = port_hit0 || addr_hit || flow_hit;

    // or-ing the masks means a monitor appears once however many methods match
    wire [9:0] mirror = (hit0 ? mon0_mask : 10'h000)
                      | (port_hit1 ? mon1_mask : 10'h000);

    ////////////////////////////////////////////////////////////////////////////
    // registered result and statistics
    always_ff @(posedge clock) begin
        if (rst) begin
            res <= '0;
        end else begin
            res.valid       <= req.valid;
            res.discard     <= req.valid && discard;
            res.fwd_mask    <= req.valid ? fwd : 10'h000;
            res.mirror_mask <= req.valid ? mirror : 10'h000;
        end
    end

    // counters wrap; software keeps long term totals
    always_ff @(posedge clock) begin
        if (rst) begin
            frame_cnt_reg   <= 16'h0000;
            discard_cnt_reg <= 16'h0000;
        end else if (req.valid) begin
            frame_cnt_reg <= frame_cnt_reg + 16'h0001;
            if (discard) begin
                discard_cnt_reg <= discard_cnt_reg + 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    logic mc_grp_ok;
    always_comb begin
        mc_grp_ok = 1'b1;
        for (int g = 0; g < NUM_GROUPS; g++) begin
            if (!$onehot0(mc_dest & memb_reg[g])) begin
                mc_grp_ok = 1'b0;
            end
        end
    end

    chk_uc_discard: assert property (@(posedge clock) disable iff (rst)
        req.valid && !req.multicast && req.dst_trunk && src_in[req.dst_group]
        |=> res.discard && res.fwd_mask == 10'h000)
        else $error("unicast into own group was not discarded");

    chk_uc_member: assert property (@(posedge clock) disable iff (rst)
        req.valid && !req.multicast && req.dst_trunk && !uc_drop
        |=> res.fwd_mask == ($past(sel_mask[req.dst_group]) & ~$past(mon_all)))
        else $error("unicast trunk port differs from the selector slot");

    chk_uc_single: assert property (@(posedge clock) disable iff (rst)
        res.valid && !$past(req.multicast) |-> $onehot0(res.fwd_mask))
        else $error("unicast frame sent to more than one port");

    chk_mc_no_src: assert property (@(posedge clock) disable iff (rst)
        req.valid && req.multicast |=> (res.fwd_mask & $past(src_mask | excl_all)) == 10'h000)
        else $error("multicast returned to its ingress port or group");

    chk_mc_one_grp: assert property (@(posedge clock) disable iff (rst)
        req.valid && req.multicast |-> mc_grp_ok)
        else $error("multicast kept two members of one group");

    chk_monitor_excl: assert property (@(posedge clock) disable iff (rst)
        req.valid ##1 res.valid |-> (res.fwd_mask & $past(mon_all)) == 10'h000)
        else $error("monitor port carried switched traffic");

    chk_flow_mirror: assert property (@(posedge clock) disable iff (rst)
        req.valid && ctrl_reg[CTRL_FLOW_EN] && fwd_pair && mon_reg[MON0_EN]
        |=> (res.mirror_mask & $past(mon0_mask)) != 10'h000)
        else $error("flow match not copied to monitor");

    chk_rev_gate: assert property (@(posedge clock) disable iff (rst)
        req.valid && !ctrl_reg[CTRL_FLOW_REV] && rev_pair && !fwd_pair && !addr_hit
        && !port_hit0 && !port_hit1 |=> res.mirror_mask == 10'h000)
        else $error("reverse flow copied while reverse match is off");

    chk_axi_wresp: assert property (@(posedge clock) disable iff (rst)
        wr_go |=> s_axi_bvalid ##0 !s_axi_awready && !s_axi_wready)
        else $error("write response missing after address and data");

endmodule

// File: dv/tmps_search_model.sv
// search engine stand-in; expects go to change just after a rising edge
`timescale 1ns/100ps
module tmps_search_model (
    input  wire logic                clock,
    input  wire logic                go,
    input  wire tmps_pkg::tmps_req_t frame,
    output tmps_pkg::tmps_req_t      req
);
    // idle fields show the inverse so a stale entry never looks fresh
    always_ff @(posedge clock) req <= go ? frame : {1'b0, ~frame[120:0]};
endmodule

// File: dv/tmps_select_tb_top.sv
// selector bench: axi4-lite setup, then lookups; expects answers one cycle later
`timescale 1ns/100ps
module tmps_select_tb_top;
    import tmps_pkg::*;
    localparam logic [47:0] SA = 48'h1234_5678;
    localparam logic [47:0] DA = 48'h9abc_def0;
    logic        clock = 0, rst = 1, go = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
    logic        awr, wrd, bv, arr, rv, k;
    logic [7:0]  aa = 0;
    logic [31:0] wd = 0, rdd, d;
    logic [1:0]  br, rr, rp, fl = 0;
    logic [3:0]  ws = 4'hf;
    int          errors = 0, check_count = 0;
    tmps_req_t   f = '0, req;
    tmps_res_t   res;
    logic [39:0] setup [5] = '{{8'h20, 32'h3}, {8'h24, 32'hc}, {8'h44, 32'h3232_3232},
                               {OFS_FSA_LO, SA[31:0]}, {OFS_FDA_LO, DA[31:0]}};
    tmps_search_model sm (.clock(clock), .go(go), .frame(f), .req(req));
    tmps_select uut (.clock(clock), .rst(rst), .req(req), .res(res), .s_axi_awaddr(aa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
        .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(bry), .s_axi_araddr(aa), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry));
    always #2.5 clock = ~clock;
    task automatic ck(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        errors += (s !== e);
        if (s !== e) $display("[ERR] %0t seen %h expected %h", $time, s, e);
    endtask
    // one access at a time; each channel drops only once its ready is seen
    task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge clock);
        {aa, wd} <= {a, v};
        {awv, wv, bry, arv, rry} <= {w, w, w, !w, !w};
        do begin
            @(posedge clock);
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
            if (arr) arv <= 1'b0;
        end while (!(bv || rv));
        {d, rp} = {rdd, w ? br : rr};
    endtask
    task automatic look(input logic mc, sw, tr, input logic [3:0] sp, dp, input logic [9:0] vl);
        @(posedge clock);
        f <= '{1'b1, mc, sp, sw ? DA : SA, sw ? SA : DA, dp, tr, 3'h1, fl[1], fl[0], vl};
        go <= 1'b1;
        @(posedge clock);
        go <= 1'b0;
        @(posedge clock);
        #1;
    endtask
    task automatic close_out(input int hung);
        errors += hung;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // the tests need about 120 cycles; a hang counts as a mismatch
    initial #20000 close_out(1);
    initial begin
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        axi(0, 8'hfc, 0);
        ck(rp, RESP_SLVERR);
        ck(d, 32'h0);
        foreach (setup[i]) axi(1, setup[i][39:32], setup[i][31:0]);
        for (int m = 0; m < 4; m++) begin
            axi(1, OFS_CTRL, m);
            k = ^(((m == 1) ? SA : (m == 2) ? DA : SA ^ DA) & 48'h2492_4924_9249);
            look(0, 0, 1, 0, 2, 0);
            ck(res.fwd_mask, k ? 10'h008 : 10'h004);
            look(0, 0, 1, 3, 2, 0);
            ck({res.valid, res.discard, res.fwd_mask}, 12'hc00);
        end
        look(1, 0, 0, 0, 0, 10'h07f);
        ck(res.fwd_mask, k ? 10'h078 : 10'h074);
        // ring mode lets the ingress port number pick the slot
        axi(1, OFS_CTRL, 32'h7);
        look(0, 0, 1, 5, 2, 0);
        ck(res.fwd_mask, 10'h008);
        $display("test trunks done");
        axi(1, OFS_CTRL, 32'h18);
        axi(1, OFS_MON, 32'h0004_3617);
        ck(rp, RESP_OKAY);
        look(0, 1, 0, 4, 7, 0);
        ck({res.mirror_mask, res.fwd_mask}, 20'h20000);
        look(0, 0, 0, 0, 4, 0);
        ck({res.mirror_mask, res.fwd_mask}, 20'h30010);
        // flow on, reverse off, address match on the destination entry flag
        axi(1, OFS_CTRL, 32'h28);
        fl = 2'b10;
        look(0, 1, 0, 0, 5, 0);
        ck({res.mirror_mask, res.fwd_mask}, 20'h00020);
        fl = 2'b01;
        look(0, 1, 0, 0, 5, 0);
        ck({res.mirror_mask, res.fwd_mask}, 20'h20020);
        $display("test mirrors done");
        // fourteen lookups so far, four of them discarded
        axi(0, OFS_STAT, 0);
        ck(d, 32'h0004_000e);
        axi(0, 8'h44, 0);
        ck(d, 32'h3232_3232);
        ws <= 4'h1;
        axi(1, 8'h44, 32'h54);
        ck(rp, RESP_OKAY);
        axi(0, 8'h44, 0);
        ck(d, 32'h3232_3254);
        $display("test registers done");
        close_out(0);
    end
endmodule
